// ===== bench/mif_filter_checker.sv
// concurrent checks on the filter top ports
// assumes bound into mif_filter, one clock domain
`timescale 1ns/1ps
module mif_filter_checker #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic                       ref_clk,
  input wire logic                       rstn,
  input wire logic                       clkEn,
  input wire logic                       filterWrite,
  input wire logic [2:0]                 filterCoef,
  input wire logic [2:0]                 tempOsr,
  input wire logic [2:0]                 pressOsr,
  input wire logic                       measStart,
  input wire logic                       adcReady,
  input wire logic [mif_pkg::DATA_W-1:0] tempOut,
  input wire logic [mif_pkg::DATA_W-1:0] pressOut,
  input wire logic [mif_pkg::HUM_W-1:0]  humOut,
  input wire logic                       resultStrobe,
  input wire logic                       periodDone,
  input wire logic                       busy,
  input wire logic                       filterActive
);
  import mif_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_COEF_LOAD: assert property (filterWrite && clkEn |=>
    filterActive == ($past(filterCoef) != 3'h0)) else $error("coef load wrong");
  AST_ACTIVE_HOLD: assert property (!filterWrite && clkEn |=>
    $stable(filterActive)) else $error("filter setting moved without write");
  AST_TEMP_MARK: assert property (measStart && !busy && clkEn && tempOsr == 3'h0
    |=> tempOut == SKIP_MARKER) else $error("temp marker missing");
  AST_PRESS_MARK: assert property (measStart && !busy && clkEn && pressOsr == 3'h0
    |=> (pressOut == SKIP_MARKER) [*3]) else $error("press marker missing");
  AST_TEMP_STROBE: assert property (!$stable(tempOut) |-> resultStrobe)
    else $error("temp write without strobe");
  AST_PRESS_STROBE: assert property (!$stable(pressOut) |-> resultStrobe)
    else $error("press write without strobe");
  AST_HUM_STROBE: assert property (!$stable(humOut) |-> resultStrobe)
    else $error("hum write without strobe");
  AST_BUSY_START: assert property (measStart && !busy && clkEn |=> busy)
    else $error("start not taken");
  cover property (periodDone);
  cover property (filterWrite && filterCoef == 3'h4);
  cover property ($fell(adcReady));
endmodule : mif_filter_checker
bind mif_filter mif_filter_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.ref_clk(ref_clk),
  .rstn(rstn), .clkEn(clkEn), .filterWrite(filterWrite), .filterCoef(filterCoef),
  .tempOsr(tempOsr), .pressOsr(pressOsr), .measStart(measStart), .adcReady(adcReady),
  .tempOut(tempOut), .pressOut(pressOut), .humOut(humOut), .resultStrobe(resultStrobe),
  .periodDone(periodDone), .busy(busy), .filterActive(filterActive));

// ===== bench/mif_host_model.sv
// host side model: stalls the drain on request, latches the temperature output at period end
// assumes one clock shared with the filter
`timescale 1ns/1ps
module mif_host_model (
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  input  wire logic                       holdReq,
  input  wire logic                       periodDone,
  input  wire logic [mif_pkg::DATA_W-1:0] tempOut,
  output logic                            readLock,
  output logic      [mif_pkg::DATA_W-1:0] tempSeen
);
  import mif_pkg::*;
  assign readLock = holdReq;
  // host reads the temperature result register once the period has ended
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tempSeen <= MEM_RESET;
    end else if (periodDone) begin
      tempSeen <= tempOut;
    end
  end
endmodule : mif_host_model

// ===== bench/tb.sv
// self-checking bench for the measurement filter
// assumes mif_pkg, the design and the host model are compiled first
`timescale 1ns/1ps
module tb;
  import mif_pkg::*;
  logic ref_clk, rstn, clkEn, filterWrite, humEnable, measStart;
  logic adcValid, adcReady, readLock, holdReq;
  logic resultStrobe, periodDone, busy, sampleError, filterActive;
  logic [2:0] filterCoef, tempOsr, pressOsr;
  mif_kind_e adcKind;
  logic [DATA_W-1:0] adcData, tempOut, pressOut, tempSeen;
  logic [HUM_W-1:0] humOut;
  int fail_count = 0;
  int n_tests = 0;

  mif_filter DUT (.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .filterWrite(filterWrite),
    .filterCoef(filterCoef), .tempOsr(tempOsr), .pressOsr(pressOsr), .humEnable(humEnable),
    .measStart(measStart), .adcValid(adcValid), .adcReady(adcReady), .adcKind(adcKind),
    .adcData(adcData), .readLock(readLock), .tempOut(tempOut), .pressOut(pressOut),
    .humOut(humOut), .resultStrobe(resultStrobe), .periodDone(periodDone), .busy(busy),
    .sampleError(sampleError), .filterActive(filterActive));
  mif_host_model u_host (.ref_clk(ref_clk), .rstn(rstn), .holdReq(holdReq),
    .periodDone(periodDone), .tempOut(tempOut), .readLock(readLock), .tempSeen(tempSeen));

  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic check(string what, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic beat(mif_kind_e k, logic [DATA_W-1:0] d);
    adcValid = 1;
    adcKind = k;
    adcData = d;
    while (adcReady !== 1'b1) step();
    step();
  endtask : beat

  task automatic set_coef(logic [2:0] c);
    filterCoef = c;
    filterWrite = 1;
    step();
    filterWrite = 0;
  endtask : set_coef

  task automatic run(logic [2:0] t, logic [2:0] p, logic h, logic [DATA_W-1:0] td,
                     logic [DATA_W-1:0] pd, logic [DATA_W-1:0] hd);
    while (busy !== 1'b0) step();
    tempOsr = t;
    pressOsr = p;
    humEnable = h;
    measStart = 1;
    step();
    measStart = 0;
    if (t != 3'h0) beat(KIND_TEMP, td);
    if (p != 3'h0) beat(KIND_PRESS, pd);
    if (h) beat(KIND_HUM, hd);
    adcValid = 0;
    while (periodDone !== 1'b1) step();
    step();
  endtask : run

  task automatic t_reset();
    check("tempOut", tempOut, OUT_RESET);
    check("pressOut", pressOut, OUT_RESET);
    check("humOut", {4'h0, humOut}, 20'h0_0000);
    check("active", {19'h0_0000, filterActive}, 20'h0_0000);
  endtask : t_reset

  task automatic t_off();
    set_coef(COEF_OFF);
    run(3'h3, 3'h1, 1'b1, 20'hF_FFFF, 20'hF_FFFF, 20'h0_1234);
    check("temp 18b", tempOut, 20'hF_FFFC);
    check("press 16b", pressOut, 20'hF_FFF0);
    check("hum", {4'h0, humOut}, 20'h0_1234);
    run(3'h5, 3'h5, 1'b0, 20'h1_2345, 20'h5_4321, 20'h0_0000);
    check("temp raw", tempOut, 20'h1_2345);
    check("host read", tempSeen, 20'h1_2345);
    check("press raw", pressOut, 20'h5_4321);
    check("hum kept", {4'h0, humOut}, 20'h0_1234);
  endtask : t_off

  task automatic t_coef();
    longint k;
    longint m;
    for (int c = 1; c <= 4; c++) begin
      k = 64'd1 << c;
      set_coef(c[2:0]);
      check("active", {19'h0_0000, filterActive}, 20'h0_0001);
      run(3'h5, 3'h5, 1'b0, 20'h0_0000, 20'hF_FFFF, 20'h0_0000);
      check("seed", pressOut, 20'hF_FFFF);
      run(3'h1, 3'h5, 1'b0, 20'h1_0003, 20'h0_0000, 20'h0_0000);
      check("temp f", tempOut, 20'(64'h1_0003 / k));
      check("press f", pressOut, 20'(64'hF_FFFF * (k - 1) / k));
    end
    m = 64'h1_0003 / 16;
    for (int i = 2; i <= 22; i++) begin
      run(3'h2, 3'h5, 1'b1, 20'h1_0003, 20'h0_0000, 20'h0_0000);
      m = (m * 15 + 64'h1_0003) / 16;
      check("step", tempOut, 20'(m));
    end
    check("75pct", {19'h0_0000, tempOut >= 20'h0_C002}, 20'h0_0001);
  endtask : t_coef

  task automatic t_skip();
    set_coef(3'h1);
    run(3'h5, 3'h5, 1'b0, 20'h0_1000, 20'h0_2000, 20'h0_0000);
    run(3'h0, 3'h5, 1'b0, 20'h0_0000, 20'h0_2000, 20'h0_0000);
    check("temp mark", tempOut, SKIP_MARKER);
    run(3'h5, 3'h5, 1'b0, 20'h0_3000, 20'h0_2000, 20'h0_0000);
    check("temp resume", tempOut, 20'h0_2000);
    run(3'h0, 3'h0, 1'b0, 20'h0_0000, 20'h0_0000, 20'h0_0000);
    check("press mark", pressOut, SKIP_MARKER);
    set_coef(3'h1);
    run(3'h5, 3'h5, 1'b0, 20'h0_7000, 20'h0_4000, 20'h0_0000);
    check("temp reinit", tempOut, 20'h0_7000);
  endtask : t_skip

  task automatic t_fifo();
    holdReq = 1;
    for (int i = 0; i < FIFO_DEPTH; i++) beat(KIND_NONE, 20'h0_0000);
    adcValid = 0;
    step();
    check("full", {19'h0_0000, adcReady}, 20'h0_0000);
    clkEn = 0;
    holdReq = 0;
    repeat (3) step();
    check("frozen", {19'h0_0000, adcReady}, 20'h0_0000);
    clkEn = 1;
    repeat (FIFO_DEPTH + 4) step();
    check("drained", {19'h0_0000, adcReady}, 20'h0_0001);
    check("error", {19'h0_0000, sampleError}, 20'h0_0001);
    run(3'h0, 3'h0, 1'b0, 20'h0_0000, 20'h0_0000, 20'h0_0000);
    check("error clr", {19'h0_0000, sampleError}, 20'h0_0000);
  endtask : t_fifo

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    #(30000 * 100);
    fail_count++;
    test_done();
  end

  initial begin
    rstn = 0;
    clkEn = 1;
    filterWrite = 0;
    filterCoef = 3'h0;
    tempOsr = 3'h0;
    pressOsr = 3'h0;
    humEnable = 0;
    measStart = 0;
    adcValid = 0;
    adcKind = KIND_NONE;
    adcData = 20'h0_0000;
    holdReq = 0;
    repeat (4) @(posedge ref_clk);
    #1;
    rstn = 1;
    step();
    step();
    t_reset();
    t_off();
    t_coef();
    t_skip();
    t_fifo();
    test_done();
  end
endmodule : tb

// ===== design/mif_fifo.sv
// result fifo between conversion source and filter
// assumes depth is a power of two, one clock, clkEn gates all state
`timescale 1ns/1ps
module mif_fifo #(
  parameter int WIDTH = mif_pkg::FIFO_W,
  parameter int DEPTH = mif_pkg::FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             clkEn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  import mif_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             ready_reg;

  wire push = inValid & ready_reg;
  wire pop  = outValid & outReady;

  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign inReady    = ready_reg;
  assign outValid   = count_reg != '0;
  assign outData    = store[rdPtr_reg];

  always_ff @(posedge ref_clk) begin
    if (clkEn && push) begin
      store[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else if (clkEn) begin
      wrPtr_reg <= wrPtr_reg + AW'(push);
      rdPtr_reg <= rdPtr_reg + AW'(pop);
      count_reg <= count_next;
      ready_reg <= count_next != FULL_COUNT;
    end
  end

endmodule : mif_fifo

// ===== design/mif_filter.sv
// post-measurement filter for temperature and pressure results
// assumes conversion results and settings come from logic on ref_clk
`timescale 1ns/1ps
module mif_filter #(
  parameter int FIFO_DEPTH = mif_pkg::FIFO_DEPTH
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic                          clkEn,
  input  wire logic                          filterWrite,
  input  wire logic [2:0]                    filterCoef,
  input  wire logic [2:0]                    tempOsr,
  input  wire logic [2:0]                    pressOsr,
  input  wire logic                          humEnable,
  input  wire logic                          measStart,
  input  wire logic                          adcValid,
  output logic                               adcReady,
  input  wire mif_pkg::mif_kind_e            adcKind,
  input  wire logic [mif_pkg::DATA_W-1:0]    adcData,
  input  wire logic                          readLock,
  output logic      [mif_pkg::DATA_W-1:0]    tempOut,
  output logic      [mif_pkg::DATA_W-1:0]    pressOut,
  output logic      [mif_pkg::HUM_W-1:0]     humOut,
  output logic                               resultStrobe,
  output logic                               periodDone,
  output logic                               busy,
  output logic                               sampleError,
  output logic                               filterActive
);
  import mif_pkg::*;

  // keeps the upper bits that the resolution allows, clears the rest
  function automatic logic [DATA_W-1:0] keepMask(input logic [2:0] osr, input logic on);
    logic [GUARD_W-1:0] drop;
    drop = '0;
    if (!on && osr < OSR_FULL) begin
      drop = GUARD_W'(OSR_FULL - osr);
    end
    keepMask = ~((DATA_W'(1) << drop) - DATA_W'(1));
  endfunction : keepMask

  // settings and period state
  logic [2:0]        coef_reg;
  logic [2:0]        tempOsr_reg;
  logic [2:0]        pressOsr_reg;
  logic              busy_reg;
  logic              active_reg;
  mif_state_e        state_reg;
  mif_state_e        state_next;
  logic              tempWait_reg;
  logic              pressWait_reg;
  logic              humWait_reg;

  // output registers
  logic [DATA_W-1:0] tempOut_reg;
  logic [DATA_W-1:0] pressOut_reg;
  logic [HUM_W-1:0]  humOut_reg;
  logic              strobe_reg;
  logic              done_reg;
  logic              error_reg;

  // fifo output side
  logic              qValid;
  logic [FIFO_W-1:0] qData;

  mif_lane_if tempLane ();
  mif_lane_if pressLane ();

  mif_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .inValid  (adcValid),
    .inReady  (adcReady),
    .inData   ({adcKind, adcData}),
    .outValid (qValid),
    .outReady (~readLock),
    .outData  (qData)
  );

  mif_iir_lane u_tempLane (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .lif     (tempLane)
  );

  mif_iir_lane u_pressLane (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .lif     (pressLane)
  );

  // decode of the word at the fifo head
  wire              take      = qValid & ~readLock;
  wire [1:0]        qKindBits = qData[FIFO_W-1:DATA_W];
  wire [DATA_W-1:0] qSample   = qData[DATA_W-1:0];
  wire              isTemp    = qKindBits == KIND_TEMP;
  wire              isPress   = qKindBits == KIND_PRESS;
  wire              isHum     = qKindBits == KIND_HUM;

  // a sample counts only if its quantity is expected in this period
  wire tempTake  = take & isTemp & tempWait_reg;
  wire pressTake = take & isPress & pressWait_reg;
  wire humTake   = take & isHum & humWait_reg;
  wire stray     = take & ~(tempTake | pressTake | humTake);

  // period start and skip decode
  wire startOk   = measStart & (state_reg == ST_IDLE);
  wire tempRun   = tempOsr != OSR_SKIP;
  wire pressRun  = pressOsr != OSR_SKIP;
  wire tempSkip  = startOk & ~tempRun;
  wire pressSkip = startOk & ~pressRun;
  wire allIn     = ~tempWait_reg & ~pressWait_reg & ~humWait_reg;

  // coefficient to shift, saturating at sixteen
  wire              filterOn  = coef_reg != COEF_OFF;
  wire [SHIFT_W-1:0] coefShift = (coef_reg > COEF_MAX_SHIFT) ? COEF_MAX_SHIFT : coef_reg;
  wire              coefWr    = clkEn & filterWrite;

  // resolution masks for the two filtered quantities
  wire [DATA_W-1:0] tempMask  = keepMask(tempOsr_reg, filterOn);
  wire [DATA_W-1:0] pressMask = keepMask(pressOsr_reg, filterOn);

  assign tempLane.sampleValid  = clkEn & tempTake;
  assign tempLane.sampleData   = qSample;
  assign tempLane.filterClear  = coefWr;
  assign tempLane.filterOn     = filterOn;
  assign tempLane.coefShift    = coefShift;

  assign pressLane.sampleValid = clkEn & pressTake;
  assign pressLane.sampleData  = qSample;
  assign pressLane.filterClear = coefWr;
  assign pressLane.filterOn    = filterOn;
  assign pressLane.coefShift   = coefShift;

  wire [DATA_W-1:0] tempFilt  = tempLane.resultData & tempMask;
  wire [DATA_W-1:0] pressFilt = pressLane.resultData & pressMask;
  wire              anyWrite  = tempSkip | pressSkip | humTake
                                | tempLane.resultValid | pressLane.resultValid;

  // period sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (measStart) begin
          state_next = ST_COLLECT;
        end
      end
      ST_COLLECT: begin
        if (allIn) begin
          state_next = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // coefficient store
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      coef_reg <= COEF_RESET;
    end else if (coefWr) begin
      coef_reg <= filterCoef;
    end
  end

  // filter-on flag kept beside the coefficient
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      active_reg <= 1'b0;
    end else if (coefWr) begin
      active_reg <= filterCoef != COEF_OFF;
    end
  end

  // settings latched for the whole period
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tempOsr_reg  <= OSR_SKIP;
      pressOsr_reg <= OSR_SKIP;
    end else if (clkEn && startOk) begin
      tempOsr_reg  <= tempOsr;
      pressOsr_reg <= pressOsr;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // busy follows the state register one for one
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
    end else if (clkEn) begin
      busy_reg <= state_next != ST_IDLE;
    end
  end

  // expected samples of the running period
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tempWait_reg  <= 1'b0;
      pressWait_reg <= 1'b0;
      humWait_reg   <= 1'b0;
    end else if (clkEn) begin
      if (startOk) begin
        tempWait_reg  <= tempRun;
        pressWait_reg <= pressRun;
        humWait_reg   <= humEnable;
      end else begin
        tempWait_reg  <= tempWait_reg & ~tempTake;
        pressWait_reg <= pressWait_reg & ~pressTake;
        humWait_reg   <= humWait_reg & ~humTake;
      end
    end
  end

  // output data registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tempOut_reg <= OUT_RESET;
    end else if (clkEn) begin
      if (tempSkip) begin
        tempOut_reg <= SKIP_MARKER;
      end else if (tempLane.resultValid) begin
        tempOut_reg <= tempFilt;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pressOut_reg <= OUT_RESET;
    end else if (clkEn) begin
      if (pressSkip) begin
        pressOut_reg <= SKIP_MARKER;
      end else if (pressLane.resultValid) begin
        pressOut_reg <= pressFilt;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      humOut_reg <= HUM_RESET;
    end else if (clkEn && humTake) begin
      humOut_reg <= qSample[HUM_W-1:0];
    end
  end

  // status flags
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strobe_reg <= 1'b0;
      done_reg   <= 1'b0;
      error_reg  <= 1'b0;
    end else if (clkEn) begin
      strobe_reg <= anyWrite;
      done_reg   <= state_reg == ST_FINISH;
      // a stray sample in the start cycle still sets the flag
      error_reg  <= stray | (error_reg & ~startOk);
    end
  end

  assign tempOut      = tempOut_reg;
  assign pressOut     = pressOut_reg;
  assign humOut       = humOut_reg;
  assign resultStrobe = strobe_reg;
  assign periodDone   = done_reg;
  assign busy         = busy_reg;
  assign sampleError  = error_reg;
  assign filterActive = active_reg;

endmodule : mif_filter

// ===== design/mif_iir_lane.sv
// one recursive low-pass lane with its own filter memory
// assumes the top drives samples, clear and coefficient on ref_clk
`timescale 1ns/1ps
module mif_iir_lane (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic clkEn,
  mif_lane_if.lane  lif
);
  import mif_pkg::*;

  localparam int SUM_W = DATA_W + GUARD_W;

  logic [DATA_W-1:0] mem_reg;
  logic [DATA_W-1:0] mem_next;
  logic              primed_reg;
  logic              valid_reg;

  // old times (c - 1) plus new, over c, with c a power of two
  wire [SUM_W-1:0] oldWide  = {{GUARD_W{1'b0}}, mem_reg};
  wire [SUM_W-1:0] newWide  = {{GUARD_W{1'b0}}, lif.sampleData};
  wire [SUM_W-1:0] oldScale = oldWide << lif.coefShift;
  wire [SUM_W-1:0] sum      = oldScale - oldWide + newWide;
  wire [SUM_W-1:0] quot     = sum >> lif.coefShift;
  wire             passRaw  = lif.filterClear | ~primed_reg | ~lif.filterOn;

  assign mem_next = passRaw ? lif.sampleData : quot[DATA_W-1:0];

  assign lif.resultValid = valid_reg;
  assign lif.resultData  = mem_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mem_reg    <= MEM_RESET;
      primed_reg <= 1'b0;
      valid_reg  <= 1'b0;
    end else if (clkEn) begin
      valid_reg <= lif.sampleValid;
      if (lif.sampleValid) begin
        mem_reg    <= mem_next;
        primed_reg <= 1'b1;
      end else if (lif.filterClear) begin
        primed_reg <= 1'b0;
      end
    end
  end

endmodule : mif_iir_lane

// ===== shared/mif_lane_if.sv
// carrier between the filter top and one filter lane
// assumes mif_pkg is compiled first
`timescale 1ns/1ps
interface mif_lane_if;
  import mif_pkg::*;

  logic                sampleValid;
  logic [DATA_W-1:0]   sampleData;
  logic                filterClear;
  logic                filterOn;
  logic [SHIFT_W-1:0]  coefShift;
  logic                resultValid;
  logic [DATA_W-1:0]   resultData;

  modport ctrl (
    output sampleValid,
    output sampleData,
    output filterClear,
    output filterOn,
    output coefShift,
    input  resultValid,
    input  resultData
  );

  modport lane (
    input  sampleValid,
    input  sampleData,
    input  filterClear,
    input  filterOn,
    input  coefShift,
    output resultValid,
    output resultData
  );

endinterface : mif_lane_if

// ===== shared/mif_pkg.sv
// constants and types of the measurement iir filter
// assumes nothing beyond a systemverilog compiler
package mif_pkg;

  localparam int DATA_W    = 20;
  localparam int HUM_W     = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W    = DATA_W + 2;
  localparam int SHIFT_W   = 3;
  localparam int GUARD_W   = 5;

  // resolution with filter off is base plus osr minus one
  localparam logic [2:0] OSR_SKIP = 3'h0;
  localparam logic [2:0] OSR_FULL = 3'h5;

  // coefficient codes: 0 off, 1 -> 2, 2 -> 4, 3 -> 8, 4 and up -> 16
  localparam logic [2:0] COEF_OFF       = 3'h0;
  localparam logic [2:0] COEF_MAX_SHIFT = 3'h4;
  localparam logic [2:0] COEF_RESET     = 3'h0;

  localparam logic [DATA_W-1:0] SKIP_MARKER = 20'h8_0000;
  localparam logic [DATA_W-1:0] OUT_RESET   = 20'h8_0000;
  localparam logic [HUM_W-1:0]  HUM_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] MEM_RESET   = 20'h0_0000;

  typedef enum logic [1:0] {
    KIND_TEMP,
    KIND_PRESS,
    KIND_HUM,
    KIND_NONE
  } mif_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COLLECT,
    ST_FINISH
  } mif_state_e;

endpackage : mif_pkg
